/* File: core/nojg_pkg.sv */
`default_nettype none
package nojg_pkg;
   // Numeric field width on the shared output pins
   localparam int NUM_W = 16;
   localparam int JOG_AXES = 8;
   localparam int MODE_W = 3;
   // Register map (byte addresses on the Wishbone bus)
   localparam logic [3:0] ADR_PROG = 4'h0;
   localparam logic [3:0] ADR_LINE = 4'h4;
   localparam logic [3:0] ADR_OVRD = 4'h8;
   localparam logic [3:0] ADR_ERR = 4'hC;
   localparam logic [3:0] ADR_SPAN = 4'h1;
   localparam logic [3:0] ADR_JOG = 4'h2;
   localparam logic [3:0] ADR_STAT = 4'h3;
   localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;
   // Span field: start bit [3:0], end bit [7:4]
   localparam int SPAN_LO = 0;
   localparam int SPAN_HI = 4;
   localparam logic [7:0] SPAN_RST = 8'hF0;
   // Timing: controller waits before sampling the field
   localparam int SAMPLE_WAIT_MS = 30;
   localparam int CLK_HZ = 10_000_000;
   localparam int SAMPLE_WAIT_CYC = SAMPLE_WAIT_MS * (CLK_HZ / 1000);
   // Jog modes
   typedef enum logic [2:0] {
      NOJG_JOINT = 3'h0,
      NOJG_XYZ = 3'h1,
      NOJG_CYL = 3'h2,
      NOJG_XYZ3 = 3'h3,
      NOJG_TOOL = 3'h4
   } nojg_mode_e;
   // Source of numeric field
   typedef enum logic [1:0] {
      NOJG_SRC_PROG = 2'h0,
      NOJG_SRC_LINE = 2'h1,
      NOJG_SRC_ERR = 2'h3,
      NOJG_SRC_OVRD = 2'h2
   } nojg_src_e;
   // Request group from the controller
   typedef struct packed {
      logic prog;
      logic line;
      logic ovrd;
      logic err;
   } nojg_req_s;
   // In-progress status group
   typedef struct packed {
      logic prog;
      logic line;
      logic ovrd;
      logic err;
   } nojg_stat_s;
   // Per-axis jog drive
   typedef logic [JOG_AXES-1:0] nojg_axes_t;
endpackage
`default_nettype wire

/* File: core/nojg_sync.sv */
`default_nettype none
// Two-flop synchroniser for pin inputs; first stage feeds only the second
module nojg_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   // Both stages advance only when enabled
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else if (ce_i)
      begin
         meta_ff <= d_i;
         sync_ff <= meta_ff;
      end
   end
   assign q_o = sync_ff;
endmodule
`default_nettype wire

/* File: core/nojg_top.sv */
`default_nettype none
module nojg_top
   import nojg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   // Wishbone classic slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [3:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Controller pins
   input wire nojg_pkg::nojg_req_s req_i,
   input wire logic jog_enable_level_i,
   input wire logic [MODE_W-1:0] jog_mode_sel_i,
   input wire nojg_pkg::nojg_axes_t jog_plus_i,
   output logic [NUM_W-1:0] numeric_io_field_o,
   output nojg_pkg::nojg_stat_s stat_o,
   output logic jog_active_o,
   output logic [MODE_W-1:0] jog_mode_o,
   output nojg_pkg::nojg_axes_t jog_axis_o
);
   import nojg_pkg::*;

   // Synchronised pin inputs
   nojg_req_s req_s;
   logic jog_en_s;
   logic [MODE_W-1:0] mode_s;
   nojg_axes_t plus_s;
   // Previous request levels for edge detection
   nojg_req_s req_prev_ff;
   nojg_req_s req_rise;
   // Span register and source selection
   logic [7:0] span_ff;
   nojg_src_e src_ff;
   nojg_src_e nxt_src;
   logic src_load;
   nojg_stat_s stat_ff;
   logic [NUM_W-1:0] field_ff;
   logic [NUM_W-1:0] mem_rdat;
   logic [1:0] mem_radr;
   logic load_pend_ff;
   // Bus signals
   logic wb_hit;
   logic wb_ack_ff;
   logic [31:0] wb_dat_ff;
   logic val_we;
   // Jog
   logic jog_active_ff;
   logic [MODE_W-1:0] mode_ff;
   nojg_axes_t axis_ff;

   // Shift a value to the start bit, then mask it to the configured bit span
   function automatic logic [NUM_W-1:0] span_place(
      input logic [NUM_W-1:0] v,
      input logic [7:0] sp
   );
      logic [3:0] lo;
      logic [3:0] hi;
      logic [NUM_W-1:0] m;
      lo = sp[SPAN_LO +: 4];
      hi = sp[SPAN_HI +: 4];
      m = '0;
      for (int i = 0; i < NUM_W; i++)
      begin
         if (i >= int'(lo) && i <= int'(hi))
         begin
            m[i] = 1'b1;
         end
      end
      // Bits above the span width are lost; accuracy not kept
      span_place = (v << lo) & m;
   endfunction

   // Axis count allowed by a mode; unknown modes drive nothing
   function automatic logic [3:0] axis_count(input logic [MODE_W-1:0] md);
      case (md)
         NOJG_JOINT: axis_count = 4'h8;
         NOJG_XYZ: axis_count = 4'h8;
         NOJG_CYL: axis_count = 4'h8;
         NOJG_XYZ3: axis_count = 4'h6;
         NOJG_TOOL: axis_count = 4'h6;
         default: axis_count = 4'h0;
      endcase
   endfunction

   // Pins cross into the clock domain through two flops
   nojg_sync #(.W(4 + 1 + MODE_W + JOG_AXES)) u_sync (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .d_i({req_i, jog_enable_level_i, jog_mode_sel_i, jog_plus_i}),
      .q_o({req_s, jog_en_s, mode_s, plus_s})
   );

   // Value store: program, line, override, error words
   assign val_we = wb_hit && wb_we_i && wb_adr_i[1:0] == 2'h0
      && wb_sel_i[0] && wb_sel_i[1];
   nojg_valmem u_mem (
      .clk_sys_i(clk_sys_i),
      .reset_i(reset_i),
      .ce_i(ce_i),
      .we_i(val_we),
      .wadr_i(wb_adr_i[3:2]),
      .wdat_i(wb_dat_i[NUM_W-1:0]),
      .radr_i(mem_radr),
      .rdat_o(mem_rdat)
   );
   assign mem_radr = src_ff;

   // Remember last request levels
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         req_prev_ff <= '0;
      end
      else if (ce_i)
      begin
         req_prev_ff <= req_s;
      end
   end
   // Rising transitions only; a held request does not retrigger
   assign req_rise = req_s & ~req_prev_ff;

   // Pick a new source; lowest-numbered request wins on a tie
   always_comb
   begin
      nxt_src = src_ff;
      src_load = 1'b1;
      if (req_rise.prog)
      begin
         nxt_src = NOJG_SRC_PROG;
      end
      else if (req_rise.line)
      begin
         nxt_src = NOJG_SRC_LINE;
      end
      else if (req_rise.ovrd)
      begin
         nxt_src = NOJG_SRC_OVRD;
      end
      else if (req_rise.err)
      begin
         nxt_src = NOJG_SRC_ERR;
      end
      else
      begin
         src_load = 1'b0;
      end
   end

   // Source and in-progress status update together
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         src_ff <= NOJG_SRC_PROG;
         stat_ff <= '0;
      end
      else if (ce_i && src_load)
      begin
         src_ff <= nxt_src;
         stat_ff.prog <= nxt_src == NOJG_SRC_PROG;
         stat_ff.line <= nxt_src == NOJG_SRC_LINE;
         stat_ff.ovrd <= nxt_src == NOJG_SRC_OVRD;
         stat_ff.err <= nxt_src == NOJG_SRC_ERR;
      end
   end

   // Once a request has set a status, the field follows the stored value; refreshed each cycle so a
   // changing line or error number stays current
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         field_ff <= '0;
         load_pend_ff <= 1'b0;
      end
      else if (ce_i)
      begin
         load_pend_ff <= |stat_ff;
         if (load_pend_ff)
         begin
            field_ff <= span_place(mem_rdat, span_ff);
         end
      end
   end

   // Jog: drive axes only while the enable is held
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         jog_active_ff <= 1'b0;
         mode_ff <= NOJG_JOINT;
         axis_ff <= '0;
      end
      else if (ce_i)
      begin
         jog_active_ff <= jog_en_s;
         mode_ff <= mode_s;
         for (int i = 0; i < JOG_AXES; i++)
         begin
            axis_ff[i] <= jog_en_s && plus_s[i]
               && (i < int'(axis_count(mode_s)));
         end
      end
   end

   // Wishbone decode: span, jog readback, status; value word reads return RD_UNMAPPED
   assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_ff;
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         wb_ack_ff <= 1'b0;
         wb_dat_ff <= RD_UNMAPPED;
         span_ff <= SPAN_RST;
      end
      else if (ce_i)
      begin
         wb_ack_ff <= wb_hit;
         if (wb_hit && wb_we_i && wb_adr_i == ADR_SPAN && wb_sel_i[0])
         begin
            span_ff <= wb_dat_i[7:0];
         end
         case (wb_adr_i)
            ADR_SPAN: wb_dat_ff <= {24'h00_0000, span_ff};
            ADR_JOG: wb_dat_ff <= {20'h0_0000, jog_active_ff,
               mode_ff, axis_ff};
            ADR_STAT: wb_dat_ff <= {28'h000_0000, stat_ff};
            default: wb_dat_ff <= RD_UNMAPPED;
         endcase
      end
   end

   assign wb_ack_o = wb_ack_ff;
   assign wb_dat_o = wb_dat_ff;
   assign numeric_io_field_o = field_ff;
   assign stat_o = stat_ff;
   assign jog_active_o = jog_active_ff;
   assign jog_mode_o = mode_ff;
   assign jog_axis_o = axis_ff;

   // Checks
   AST_PROG_FLAG: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && req_rise.prog |=> stat_o.prog)
      else $error("program status missing");
   AST_LINE_FLAG: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && req_rise.line && !req_rise.prog
      |=> stat_o.line && !stat_o.err)
      else $error("line status wrong");
   AST_OVRD_FLAG: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && req_rise.ovrd && !req_rise.prog && !req_rise.line
      |=> stat_o.ovrd)
      else $error("override status missing");
   AST_ERR_FLAG: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && req_rise.err && req_rise == 4'h1
      |=> stat_o.err)
      else $error("error status missing");
   AST_ONEHOT: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) $onehot0(stat_o))
      else $error("more than one status");
   AST_HOLD: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && req_prev_ff == req_s |=> $stable(stat_o))
      else $error("held request retriggered");
   AST_JOG_STOP: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && !jog_en_s |=> jog_axis_o == '0 && !jog_active_o)
      else $error("jog output without enable");
   AST_AXIS6: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) ce_i && mode_s == NOJG_TOOL |=> jog_axis_o[7:6] == 2'h0)
      else $error("tool mode drove extra axis");
   AST_ACK_ONE: assert property (@(posedge clk_sys_i) disable iff
      (reset_i) wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   COV_PROG: cover property (@(posedge clk_sys_i) req_rise.prog);
   COV_ERR: cover property (@(posedge clk_sys_i) stat_o.err);
   COV_JOG: cover property (@(posedge clk_sys_i) jog_active_o
      && jog_axis_o != '0);
endmodule
`default_nettype wire

/* File: core/nojg_valmem.sv */
`default_nettype none
// Four-word value store; read data leaves a register
module nojg_valmem
   import nojg_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic we_i,
   input wire logic [1:0] wadr_i,
   input wire logic [NUM_W-1:0] wdat_i,
   input wire logic [1:0] radr_i,
   output logic [NUM_W-1:0] rdat_o
);
   logic [NUM_W-1:0] mem_ff [4];
   logic [NUM_W-1:0] rdat_ff;
   // Write port
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < 4; i++)
         begin
            mem_ff[i] <= '0;
         end
      end
      else if (ce_i && we_i)
      begin
         mem_ff[wadr_i] <= wdat_i;
      end
   end
   // Registered read port
   always_ff @(posedge clk_sys_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rdat_ff <= '0;
      end
      else if (ce_i)
      begin
         rdat_ff <= mem_ff[radr_i];
      end
   end
   assign rdat_o = rdat_ff;
endmodule
`default_nettype wire

/* File: sim/nojg_plc.sv */
`default_nettype none
// Behavioural sequencer that drives the request and jog pins
module nojg_plc
   import nojg_pkg::*;
#(
   // Settle wait in cycles; shortened stand-in for the long wait
   parameter int WAIT_CYC = 12
) (
   input wire logic clk_sys_i,
   input wire logic [NUM_W-1:0] field_i,
   output nojg_pkg::nojg_req_s req_o,
   output logic en_o,
   output logic [MODE_W-1:0] mode_o,
   output nojg_pkg::nojg_axes_t plus_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Field value taken after the settle wait
   logic [NUM_W-1:0] seen;
   // All pins idle at time zero
   initial
   begin
      req_o = '0;
      en_o = 1'b0;
      mode_o = '0;
      plus_o = '0;
   end
   // Set request levels, then read the field only once it settled
   task automatic drive_req(input logic [3:0] r);
      @(posedge clk_sys_i);
      req_o <= r;
      repeat (WAIT_CYC) @(posedge clk_sys_i);
      seen = field_i;
   endtask
   // Jog levels; mode codes 0..4 are the documented ones
   task automatic drive_jog(input logic e, input logic [2:0] m,
                            input logic [7:0] p);
      @(posedge clk_sys_i);
      en_o <= e;
      mode_o <= m;
      plus_o <= p;
   endtask
endmodule
`default_nettype wire

/* File: sim/nojg_top_test.sv */
`default_nettype none
// Self-checking bench for the numeric output and jog pin block
module nojg_top_test import nojg_pkg::*;;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys_i = 1'b0;
   logic reset_i = 1'b1;
   logic wb_cyc = 1'b0;
   logic wb_stb = 1'b0;
   logic wb_we = 1'b0;
   logic [3:0] wb_adr = '0;
   logic [31:0] wb_dat = '0;
   logic [31:0] wb_rdat;
   logic wb_ack;
   nojg_req_s req;
   logic jog_en;
   logic [MODE_W-1:0] jog_mode;
   nojg_axes_t jog_plus;
   logic [NUM_W-1:0] field;
   nojg_stat_s stat;
   logic active;
   logic [MODE_W-1:0] mode;
   nojg_axes_t axis;
   int n_errors = 0;
   int total_checks = 0;
   // Reference model: value words and span as software wrote them
   int vals[4];
   int span_v = 'hF0;
   // 10 MHz clock
   always #50 clk_sys_i = ~clk_sys_i;
   nojg_top DUT (
      .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
      .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
      .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_dat),
      .wb_dat_o(wb_rdat), .wb_ack_o(wb_ack), .req_i(req),
      .jog_enable_level_i(jog_en), .jog_mode_sel_i(jog_mode),
      .jog_plus_i(jog_plus), .numeric_io_field_o(field),
      .stat_o(stat), .jog_active_o(active), .jog_mode_o(mode),
      .jog_axis_o(axis)
   );
   nojg_plc plc (
      .clk_sys_i(clk_sys_i), .field_i(field), .req_o(req),
      .en_o(jog_en), .mode_o(jog_mode), .plus_o(jog_plus)
   );
   // Counts and verdict; the only place the run ends
   task automatic complete_run();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Compare one result with the model
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Classic cycle; the wait for ack is bounded so a dead slave ends it
   task automatic wb(input logic we, input logic [3:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      @(posedge clk_sys_i);
      while (wb_ack !== 1'b1)
      begin
         n++;
         if (n > 20)
         begin
            n_errors++;
            complete_run();
         end
         @(posedge clk_sys_i);
      end
      q = wb_rdat;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk_sys_i);
   endtask
   // Value placed in the start..end span; bits beyond it dropped
   function automatic logic [31:0] fexp(input int v, input int sp);
      logic [31:0] r;
      r = '0;
      for (int b = sp % 16; b <= sp / 16; b++)
         r[b] = v[b - sp % 16];
      return r;
   endfunction
   // Main sequence
   initial
   begin
      logic [31:0] q;
      int v;
      int c;
      void'($urandom(46));
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(posedge clk_sys_i);
      wb(1'b0, 4'h1, '0, q);
      chk(q, 32'(span_v));
      wb(1'b0, 4'h5, '0, q);
      chk(q, '0);
      // Each source in turn; status must outlive the request pulse
      for (int i = 0; i < 4; i++)
      begin
         vals[i] = $urandom & 'hFFFF;
         wb(1'b1, 4'(i * 4), 32'(vals[i]), q);
         plc.drive_req(4'h8 >> i);
         chk(32'(stat), 32'(8 >> i));
         chk(32'(plc.seen), fexp(vals[i], span_v));
         plc.drive_req(4'h0);
         chk(32'(stat), 32'(8 >> i));
         wb(1'b0, 4'h3, '0, q);
         chk(q, 32'(8 >> i));
      end
      // Held line request must not fire again after program request
      plc.drive_req(4'h4);
      plc.drive_req(4'hC);
      plc.drive_req(4'h4);
      chk(32'(stat), 32'h8);
      chk(32'(plc.seen), fexp(vals[0], span_v));
      plc.drive_req(4'h0);
      plc.drive_req(4'hF);
      chk(32'(stat), 32'h8);
      // Random span with start not above end
      v = $urandom % 16;
      span_v = v + 16 * (v + $urandom % (16 - v));
      wb(1'b1, 4'h1, 32'(span_v), q);
      plc.drive_req(4'hF);
      chk(32'(plc.seen), fexp(vals[0], span_v));
      // Every mode code, with and without enable
      for (int m = 0; m < 8; m++)
         for (int e = 0; e < 2; e++)
         begin
            v = $urandom & 'hFF;
            plc.drive_jog(e[0], 3'(m), 8'(v));
            repeat (4) @(posedge clk_sys_i);
            c = m < 3 ? 8 : (m < 5 ? 6 : 0);
            v = e * (v & ((1 << c) - 1));
            chk(32'(axis), 32'(v));
            if (m < 5)
            begin
               chk(32'(active), 32'(e));
               if (e == 1)
                  chk(32'(mode), 32'(m));
            end
         end
      complete_run();
   end
endmodule
`default_nettype wire
